// [core/ssc_pkg.sv]
package ssc_pkg;
	localparam int DATA_W = 64;
	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int ROWS = 6;
	localparam int ROW_IDX_W = 3;
	localparam int CMD_ADDR_W = 28;
	localparam int OPEN_PAGES = 4;
	localparam int WBUF_DEPTH = 4;
	localparam int WBUF_PTR_W = 2;
	localparam int REFQ_DEPTH = 1024;
	localparam int REFQ_CNT_W = 11;
	localparam int TMR_W = 4;
	localparam int REF_INT_W = 12;
	localparam int CL_SHIFT_W = 4;
	localparam logic [REFQ_CNT_W-1:0] REFQ_FULL = 11'h400;
	localparam logic [REF_INT_W-1:0] REF_INT_DEF = 12'h3cf;
	localparam logic [TMR_W-1:0] TRP_DEF = 4'h3;
	localparam logic [TMR_W-1:0] TRCD_DEF = 4'h3;
	localparam logic [TMR_W-1:0] TRC_DEF = 4'h9;
	localparam logic [1:0] CL2 = 2'h2;
	localparam logic [1:0] CL3 = 2'h3;
	localparam logic [ADDR_W-1:0] A10_ALL_BANKS = 13'h0400;
	localparam int A10_POS = 10;
	// Organisation codes: column width 8, 9, 9, 10, 10 for 2M..32M modules
	localparam logic [2:0] ORG_2M = 3'h0;
	localparam logic [2:0] ORG_4M = 3'h1;
	localparam logic [2:0] ORG_8M = 3'h2;
	localparam logic [2:0] ORG_16M = 3'h3;
	localparam logic [2:0] ORG_32M = 3'h4;
	typedef enum logic [3:0] {
		SSC_CMD_NOP = 4'h7,
		SSC_CMD_ACT = 4'h3,
		SSC_CMD_RD = 4'h5,
		SSC_CMD_WR = 4'h4,
		SSC_CMD_PRE = 4'h2,
		SSC_CMD_REF = 4'h1
	} ssc_cmd_t;
	typedef enum logic [2:0] {
		SSC_IDLE = 3'h0,
		SSC_PRE = 3'h1,
		SSC_ACT = 3'h2,
		SSC_COL = 3'h3,
		SSC_REF_PRE = 3'h4,
		SSC_REF = 3'h5,
		SSC_WAIT = 3'h6
	} ssc_state_t;
endpackage

// [core/ssc_controller.sv]
`timescale 1ns/10ps
// What this block does
// [R01] 64-bit data path, 100 or 133 MHz
// [R02] Thirteen-bit multiplexed row/column address bus
// [R03] Two-bit bank select per access
// [R04] Maps 2M to 32M deep x64 modules
// [R05] Asymmetric row/column mapping only
// [R06] Six row selects, each driven twice
// [R07] CAS latency two or three for capture
// [R08] Each module side is its own row
// [R09] 1024-entry pending refresh queue
// [R10] Up to four pages kept open
// [R11] Open pages in any bank
// [R12] Timing and organisation from configuration inputs
// [R13] Six clock enables, low for power-down
// [R14] Firmware lowers clock when too many rows
// [R15] Refresh by auto-refresh command only
// [R16] No ECC generation or checking
// [R17] x8 and x16 devices supported
// [R18] Buffered writes, reads bypass them
// [R19] Page miss: precharge, activate, then column
module ssc_controller (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [ssc_pkg::CMD_ADDR_W-1:0] req_addr_i,
	input wire logic [ssc_pkg::ROW_IDX_W-1:0] req_row_i,
	input wire logic [ssc_pkg::DATA_W-1:0] req_wdata_i,
	input wire logic [7:0] req_wmask_i,
	output logic req_ready_o,
	output logic rd_valid_o,
	output logic [ssc_pkg::DATA_W-1:0] rd_data_o,
	input wire logic [2:0] cfg_org_i,
	input wire logic [1:0] cfg_cas_lat_i,
	input wire logic [2:0] cfg_open_pages_i,
	input wire logic [ssc_pkg::TMR_W-1:0] cfg_trp_i,
	input wire logic [ssc_pkg::TMR_W-1:0] cfg_trcd_i,
	input wire logic [ssc_pkg::TMR_W-1:0] cfg_trc_i,
	input wire logic [ssc_pkg::REF_INT_W-1:0] cfg_ref_int_i,
	input wire logic [ssc_pkg::ROWS-1:0] cfg_pwrdn_i,
	output logic [ssc_pkg::ADDR_W-1:0] mem_mux_addr_o,
	output logic [ssc_pkg::BANK_W-1:0] mem_bank_sel_o,
	output logic [ssc_pkg::ROWS-1:0] mem_row_select_n_a_o,
	output logic [ssc_pkg::ROWS-1:0] mem_row_select_n_b_o,
	output logic [ssc_pkg::ROWS-1:0] mem_row_clk_en_o,
	output logic mem_ras_n_o,
	output logic mem_cas_n_o,
	output logic mem_we_n_o,
	output logic [7:0] mem_dqm_o,
	output logic [ssc_pkg::DATA_W-1:0] mem_dq_o,
	output logic mem_dq_oe_o,
	input wire logic [ssc_pkg::DATA_W-1:0] mem_dq_i,
	output logic [ssc_pkg::REFQ_CNT_W-1:0] refq_level_o
);
	import ssc_pkg::*;

	// Split a linear request address into row and column by organisation [R04] [R05]
	function automatic logic [ADDR_W-1:0] col_of(input logic [CMD_ADDR_W-1:0] a,
			input logic [2:0] org);
		logic [ADDR_W-1:0] c;
		c = '0;
		case (org)
			ORG_2M: c = {5'h0, a[7:0]};
			ORG_4M, ORG_8M: c = {4'h0, a[8:0]};
			default: c = {3'h0, a[9:0]};
		endcase
		return c;
	endfunction

	function automatic logic [ADDR_W-1:0] row_of(input logic [CMD_ADDR_W-1:0] a,
			input logic [2:0] org);
		logic [ADDR_W-1:0] r;
		r = '0;
		case (org)
			ORG_2M: r = {2'h0, a[20:10]};
			ORG_4M: r = {1'h0, a[22:11]};
			ORG_8M: r = a[23:11];
			ORG_16M: r = a[24:12];
			default: r = a[24:12];
		endcase
		return r;
	endfunction

	// Bank bits sit just above the column for every organisation [R03]
	function automatic logic [BANK_W-1:0] bank_of(input logic [CMD_ADDR_W-1:0] a,
			input logic [2:0] org);
		logic [BANK_W-1:0] b;
		b = '0;
		case (org)
			ORG_2M: b = a[9:8];
			ORG_4M, ORG_8M: b = a[10:9];
			default: b = a[11:10];
		endcase
		return b;
	endfunction

	// Write buffer and open-page table
	logic [WBUF_DEPTH-1:0] wb_vld_r, wb_vld_nxt;
	logic [CMD_ADDR_W-1:0] wb_addr_r [WBUF_DEPTH];
	logic [CMD_ADDR_W-1:0] wb_addr_nxt [WBUF_DEPTH];
	logic [ROW_IDX_W-1:0] wb_row_r [WBUF_DEPTH];
	logic [ROW_IDX_W-1:0] wb_row_nxt [WBUF_DEPTH];
	logic [DATA_W-1:0] wb_data_r [WBUF_DEPTH];
	logic [DATA_W-1:0] wb_data_nxt [WBUF_DEPTH];
	logic [7:0] wb_mask_r [WBUF_DEPTH];
	logic [7:0] wb_mask_nxt [WBUF_DEPTH];
	logic [OPEN_PAGES-1:0] pg_vld_r, pg_vld_nxt;
	logic [ROW_IDX_W-1:0] pg_row_r [OPEN_PAGES];
	logic [ROW_IDX_W-1:0] pg_row_nxt [OPEN_PAGES];
	logic [BANK_W-1:0] pg_bank_r [OPEN_PAGES];
	logic [BANK_W-1:0] pg_bank_nxt [OPEN_PAGES];
	logic [ADDR_W-1:0] pg_page_r [OPEN_PAGES];
	logic [ADDR_W-1:0] pg_page_nxt [OPEN_PAGES];
	logic [WBUF_PTR_W-1:0] pg_victim_r, pg_victim_nxt;

	// Command engine state
	ssc_state_t st_r, st_nxt;
	logic [TMR_W-1:0] tmr_r, tmr_nxt;
	logic [REF_INT_W-1:0] ref_tick_r, ref_tick_nxt;
	logic [REFQ_CNT_W-1:0] refq_r, refq_nxt;
	logic cur_wr_r, cur_wr_nxt;
	logic [CMD_ADDR_W-1:0] cur_addr_r, cur_addr_nxt;
	logic [ROW_IDX_W-1:0] cur_row_r, cur_row_nxt;
	logic [DATA_W-1:0] cur_data_r, cur_data_nxt;
	logic [7:0] cur_mask_r, cur_mask_nxt;
	logic [WBUF_PTR_W-1:0] cur_slot_r, cur_slot_nxt;
	logic [WBUF_PTR_W-1:0] cur_wb_r, cur_wb_nxt;
	logic [CL_SHIFT_W-1:0] rd_pipe_r, rd_pipe_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [DATA_W-1:0] rd_data_r, rd_data_nxt;
	logic ready_r, ready_nxt;
	ssc_cmd_t cmd_r, cmd_nxt;
	logic [ADDR_W-1:0] ma_r, ma_nxt;
	logic [BANK_W-1:0] ba_r, ba_nxt;
	logic [ROWS-1:0] cs_n_r, cs_n_nxt;
	logic [ROWS-1:0] cke_r, cke_nxt;
	logic [7:0] dqm_r, dqm_nxt;
	logic [DATA_W-1:0] dq_r, dq_nxt;
	logic dq_oe_r, dq_oe_nxt;

	logic hit;
	logic [WBUF_PTR_W-1:0] hit_slot;
	logic wb_free_any, wb_any;
	logic [WBUF_PTR_W-1:0] wb_free_slot, wb_pick;
	logic [2:0] lim;

	always_comb begin
		hit = 1'b0;
		hit_slot = '0;
		wb_free_any = 1'b0;
		wb_free_slot = '0;
		wb_any = 1'b0;
		wb_pick = '0;
		lim = (cfg_open_pages_i > 3'h4) ? 3'h4 : cfg_open_pages_i;
		for (int i = 0; i < OPEN_PAGES; i++) begin
			if (pg_vld_r[i] && pg_row_r[i] == cur_row_r && // [R11]
					pg_bank_r[i] == bank_of(cur_addr_r, cfg_org_i) &&
					pg_page_r[i] == row_of(cur_addr_r, cfg_org_i)) begin
				hit = 1'b1;
				hit_slot = WBUF_PTR_W'(i);
			end
		end
		for (int i = WBUF_DEPTH - 1; i >= 0; i--) begin
			if (!wb_vld_r[i]) begin
				wb_free_any = 1'b1;
				wb_free_slot = WBUF_PTR_W'(i);
			end
			if (wb_vld_r[i]) begin
				wb_any = 1'b1;
				wb_pick = WBUF_PTR_W'(i);
			end
		end
	end

	always_comb begin
		wb_vld_nxt = wb_vld_r;
		wb_addr_nxt = wb_addr_r;
		wb_row_nxt = wb_row_r;
		wb_data_nxt = wb_data_r;
		wb_mask_nxt = wb_mask_r;
		pg_vld_nxt = pg_vld_r;
		pg_row_nxt = pg_row_r;
		pg_bank_nxt = pg_bank_r;
		pg_page_nxt = pg_page_r;
		pg_victim_nxt = pg_victim_r;
		st_nxt = st_r;
		tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
		ref_tick_nxt = ref_tick_r + 1'b1;
		refq_nxt = refq_r;
		cur_wr_nxt = cur_wr_r;
		cur_addr_nxt = cur_addr_r;
		cur_row_nxt = cur_row_r;
		cur_data_nxt = cur_data_r;
		cur_mask_nxt = cur_mask_r;
		cur_slot_nxt = cur_slot_r;
		cur_wb_nxt = cur_wb_r;
		// Read capture delayed by CAS latency [R07]
		rd_pipe_nxt = {rd_pipe_r[CL_SHIFT_W-2:0], 1'b0};
		// The command leaves a flop, so the data edge is one stage later than the latency
		rd_valid_nxt = (cfg_cas_lat_i == CL2) ? rd_pipe_r[2] : rd_pipe_r[3];
		rd_data_nxt = rd_valid_nxt ? mem_dq_i : rd_data_r; // [R01] [R16]
		cmd_nxt = SSC_CMD_NOP;
		ma_nxt = ma_r;
		ba_nxt = ba_r;
		cs_n_nxt = '1;
		cke_nxt = ~cfg_pwrdn_i; // [R13]
		dqm_nxt = '0;
		dq_nxt = dq_r;
		dq_oe_nxt = 1'b0;
		// Refresh ticks queue up; saturate at full depth [R09]
		if (ref_tick_r >= cfg_ref_int_i) begin
			ref_tick_nxt = '0;
			if (refq_r != REFQ_FULL)
				refq_nxt = refq_r + 1'b1;
		end
		// Writes posted to the buffer; reads wait for the engine [R18]
		ready_nxt = 1'b0;
		if (ready_r && req_valid_i && req_write_i && wb_free_any) begin
			wb_vld_nxt[wb_free_slot] = 1'b1;
			wb_addr_nxt[wb_free_slot] = req_addr_i;
			wb_row_nxt[wb_free_slot] = req_row_i;
			wb_data_nxt[wb_free_slot] = req_wdata_i;
			wb_mask_nxt[wb_free_slot] = req_wmask_i;
		end
		case (st_r)
			SSC_IDLE: begin
				// Ready only while one more write still finds a free slot
				ready_nxt = !(wb_vld_nxt == '1);
				if (ready_r && req_valid_i && !req_write_i) begin
					// A read taken here must not be lost to refresh; it also passes writes [R18]
					ready_nxt = 1'b0;
					cur_wr_nxt = 1'b0;
					cur_addr_nxt = req_addr_i;
					cur_row_nxt = req_row_i; // [R08]
					st_nxt = SSC_WAIT;
				end else if (refq_r == REFQ_FULL || (refq_r != '0 && !req_valid_i && !wb_any)) begin
					ready_nxt = 1'b0;
					st_nxt = SSC_REF_PRE;
				end else if (wb_any && !(ready_r && req_valid_i)) begin
					ready_nxt = 1'b0;
					cur_wr_nxt = 1'b1;
					cur_wb_nxt = wb_pick;
					cur_addr_nxt = wb_addr_r[wb_pick];
					cur_row_nxt = wb_row_r[wb_pick];
					cur_data_nxt = wb_data_r[wb_pick];
					cur_mask_nxt = wb_mask_r[wb_pick];
					st_nxt = SSC_WAIT;
				end
			end
			SSC_WAIT: begin
				// Decide page hit or miss; every miss takes the victim slot [R10] [R19]
				if (hit) begin
					cur_slot_nxt = hit_slot;
					st_nxt = SSC_COL;
				end else begin
					cur_slot_nxt = pg_victim_r;
					if (lim != '0)
						pg_victim_nxt = ({1'b0, pg_victim_r} + 3'h1 >= lim) ? '0
							: pg_victim_r + 1'b1;
					st_nxt = SSC_PRE;
				end
			end
			SSC_PRE: if (tmr_r == '0) begin
				// Close whatever is open in the target bank [R19]
				cmd_nxt = SSC_CMD_PRE;
				cs_n_nxt[cur_row_r] = 1'b0; // [R06]
				ba_nxt = bank_of(cur_addr_r, cfg_org_i);
				ma_nxt = '0;
				for (int i = 0; i < OPEN_PAGES; i++)
					if (pg_row_r[i] == cur_row_r && pg_bank_r[i] == ba_nxt)
						pg_vld_nxt[i] = 1'b0;
				tmr_nxt = cfg_trp_i; // [R12]
				st_nxt = SSC_ACT;
			end
			SSC_ACT: if (tmr_r == '0) begin
				cmd_nxt = SSC_CMD_ACT;
				cs_n_nxt[cur_row_r] = 1'b0;
				ba_nxt = bank_of(cur_addr_r, cfg_org_i); // [R03]
				ma_nxt = row_of(cur_addr_r, cfg_org_i); // [R02]
				if (lim != '0) begin
					pg_vld_nxt[cur_slot_r] = 1'b1;
					pg_row_nxt[cur_slot_r] = cur_row_r;
					pg_bank_nxt[cur_slot_r] = ba_nxt;
					pg_page_nxt[cur_slot_r] = ma_nxt;
				end
				tmr_nxt = cfg_trcd_i;
				st_nxt = SSC_COL;
			end
			SSC_COL: if (tmr_r == '0) begin
				cs_n_nxt[cur_row_r] = 1'b0;
				ba_nxt = bank_of(cur_addr_r, cfg_org_i);
				ma_nxt = col_of(cur_addr_r, cfg_org_i); // [R02]
				// Auto-precharge when no pages may stay open [R10]
				if (lim == '0) begin
					ma_nxt[A10_POS] = 1'b1;
					// The bank closes itself, so its page must not be seen as open
					for (int i = 0; i < OPEN_PAGES; i++)
						if (pg_row_r[i] == cur_row_r && pg_bank_r[i] == ba_nxt)
							pg_vld_nxt[i] = 1'b0;
				end
				if (cur_wr_r) begin
					cmd_nxt = SSC_CMD_WR;
					dq_nxt = cur_data_r;
					dq_oe_nxt = 1'b1;
					dqm_nxt = ~cur_mask_r; // [R17]
					wb_vld_nxt[cur_wb_r] = 1'b0;
				end else begin
					cmd_nxt = SSC_CMD_RD;
					rd_pipe_nxt[0] = 1'b1;
				end
				tmr_nxt = cfg_cas_lat_i == CL3 ? TMR_W'(CL3) : TMR_W'(CL2);
				st_nxt = SSC_IDLE;
			end
			SSC_REF_PRE: if (tmr_r == '0) begin
				// Close all banks of all rows before refresh
				cmd_nxt = SSC_CMD_PRE;
				cs_n_nxt = '0;
				ma_nxt = A10_ALL_BANKS;
				pg_vld_nxt = '0;
				tmr_nxt = cfg_trp_i;
				st_nxt = SSC_REF;
			end
			SSC_REF: if (tmr_r == '0) begin
				cmd_nxt = SSC_CMD_REF; // [R15]
				cs_n_nxt = '0;
				if (refq_nxt != '0)
					refq_nxt = refq_nxt - 1'b1;
				tmr_nxt = cfg_trc_i;
				st_nxt = SSC_IDLE;
			end
			default: st_nxt = SSC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			wb_vld_r <= '0;
			pg_vld_r <= '0;
			pg_victim_r <= '0;
			st_r <= SSC_IDLE;
			tmr_r <= '0;
			ref_tick_r <= '0;
			refq_r <= '0;
			cur_wr_r <= 1'b0;
			cur_addr_r <= '0;
			cur_row_r <= '0;
			cur_data_r <= '0;
			cur_mask_r <= '0;
			cur_slot_r <= '0;
			cur_wb_r <= '0;
			rd_pipe_r <= '0;
			rd_valid_r <= 1'b0;
			rd_data_r <= '0;
			ready_r <= 1'b0;
			cmd_r <= SSC_CMD_NOP;
			ma_r <= '0;
			ba_r <= '0;
			cs_n_r <= '1;
			cke_r <= '0;
			dqm_r <= '0;
			dq_r <= '0;
			dq_oe_r <= 1'b0;
			for (int i = 0; i < WBUF_DEPTH; i++) begin
				wb_addr_r[i] <= '0;
				wb_row_r[i] <= '0;
				wb_data_r[i] <= '0;
				wb_mask_r[i] <= '0;
			end
			for (int i = 0; i < OPEN_PAGES; i++) begin
				pg_row_r[i] <= '0;
				pg_bank_r[i] <= '0;
				pg_page_r[i] <= '0;
			end
		end else begin
			wb_vld_r <= wb_vld_nxt;
			wb_addr_r <= wb_addr_nxt;
			wb_row_r <= wb_row_nxt;
			wb_data_r <= wb_data_nxt;
			wb_mask_r <= wb_mask_nxt;
			pg_vld_r <= pg_vld_nxt;
			pg_row_r <= pg_row_nxt;
			pg_bank_r <= pg_bank_nxt;
			pg_page_r <= pg_page_nxt;
			pg_victim_r <= pg_victim_nxt;
			st_r <= st_nxt;
			tmr_r <= tmr_nxt;
			ref_tick_r <= ref_tick_nxt;
			refq_r <= refq_nxt;
			cur_wr_r <= cur_wr_nxt;
			cur_addr_r <= cur_addr_nxt;
			cur_row_r <= cur_row_nxt;
			cur_data_r <= cur_data_nxt;
			cur_mask_r <= cur_mask_nxt;
			cur_slot_r <= cur_slot_nxt;
			cur_wb_r <= cur_wb_nxt;
			rd_pipe_r <= rd_pipe_nxt;
			rd_valid_r <= rd_valid_nxt;
			rd_data_r <= rd_data_nxt;
			ready_r <= ready_nxt;
			cmd_r <= cmd_nxt;
			ma_r <= ma_nxt;
			ba_r <= ba_nxt;
			cs_n_r <= cs_n_nxt;
			cke_r <= cke_nxt;
			dqm_r <= dqm_nxt;
			dq_r <= dq_nxt;
			dq_oe_r <= dq_oe_nxt;
		end
	end

	assign req_ready_o = ready_r;
	assign rd_valid_o = rd_valid_r;
	assign rd_data_o = rd_data_r;
	assign mem_mux_addr_o = ma_r;
	assign mem_bank_sel_o = ba_r;
	// Two copies of each select share the loading [R06]
	assign mem_row_select_n_a_o = cs_n_r;
	assign mem_row_select_n_b_o = cs_n_r;
	assign mem_row_clk_en_o = cke_r;
	assign mem_ras_n_o = cmd_r[2];
	assign mem_cas_n_o = cmd_r[1];
	assign mem_we_n_o = cmd_r[0];
	assign mem_dqm_o = dqm_r;
	assign mem_dq_o = dq_r;
	assign mem_dq_oe_o = dq_oe_r;
	assign refq_level_o = refq_r;
endmodule

// [bench/ssc_controller_properties.sv]
`timescale 1ns/10ps
module ssc_controller_properties
	import ssc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic rd_valid_o,
	input wire logic [1:0] cfg_cas_lat_i,
	input wire logic [ROWS-1:0] cfg_pwrdn_i,
	input wire logic [ADDR_W-1:0] mem_mux_addr_o,
	input wire logic [ROWS-1:0] mem_row_select_n_a_o,
	input wire logic [ROWS-1:0] mem_row_select_n_b_o,
	input wire logic [ROWS-1:0] mem_row_clk_en_o,
	input wire logic mem_ras_n_o,
	input wire logic mem_cas_n_o,
	input wire logic mem_we_n_o,
	input wire logic [REFQ_CNT_W-1:0] refq_level_o
);
	wire [2:0] cmd = {mem_ras_n_o, mem_cas_n_o, mem_we_n_o};
	wire sel = ~&mem_row_select_n_a_o;
	wire act_c = sel && cmd == 3'b011;
	wire rd_c = sel && cmd == 3'b101;
	wire wr_c = sel && cmd == 3'b100;
	wire pre_c = sel && cmd == 3'b010;
	wire ref_c = sel && cmd == 3'b001;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	property p_sel_copy;
		mem_row_select_n_a_o == mem_row_select_n_b_o;
	endproperty
	a_sel_copy: assert property (p_sel_copy) else $error("row select copies differ");
	property p_one_row;
		act_c || rd_c || wr_c |-> $onehot(~mem_row_select_n_a_o);
	endproperty
	a_one_row: assert property (p_one_row) else $error("access selects not one row");
	property p_cke;
		!$past(reset_i) |-> mem_row_clk_en_o == ~$past(cfg_pwrdn_i);
	endproperty
	a_cke: assert property (p_cke) else $error("clock enable not following power-down");
	property p_cl2;
		rd_c && cfg_cas_lat_i == CL2 |-> ##3 rd_valid_o;
	endproperty
	a_cl2: assert property (p_cl2) else $error("read data late at latency two");
	property p_cl3;
		rd_c && cfg_cas_lat_i == CL3 |-> !rd_valid_o [*4] ##1 rd_valid_o;
	endproperty
	a_cl3: assert property (p_cl3) else $error("read data misplaced at latency three");
	property p_rv_src;
		rd_valid_o |-> (cfg_cas_lat_i == CL2) ? $past(rd_c, 3) : $past(rd_c, 4);
	endproperty
	a_rv_src: assert property (p_rv_src) else $error("read data without read command");
	property p_pre_gap;
		pre_c |=> (!act_c && !rd_c && !wr_c) [*2];
	endproperty
	a_pre_gap: assert property (p_pre_gap) else $error("command too soon after precharge");
	property p_act_gap;
		act_c |=> (!rd_c && !wr_c) [*2];
	endproperty
	a_act_gap: assert property (p_act_gap) else $error("column too soon after activate");
	property p_ref_prep;
		pre_c && mem_mux_addr_o[A10_POS] |-> ##[1:16] ref_c;
	endproperty
	a_ref_prep: assert property (p_ref_prep) else $error("precharge-all without refresh");
	property p_refq;
		refq_level_o <= REFQ_FULL;
	endproperty
	a_refq: assert property (p_refq) else $error("refresh queue beyond depth");
	c_ref: cover property (ref_c);
	c_cl3: cover property (rd_valid_o && cfg_cas_lat_i == CL3);
	c_wr: cover property (wr_c);
endmodule
bind ssc_controller ssc_controller_properties u_props (.clk_sys_i, .reset_i, .rd_valid_o,
	.cfg_cas_lat_i, .cfg_pwrdn_i, .mem_mux_addr_o, .mem_row_select_n_a_o, .mem_row_select_n_b_o,
	.mem_row_clk_en_o, .mem_ras_n_o, .mem_cas_n_o, .mem_we_n_o, .refq_level_o);

// [bench/ssc_sdram_model.sv]
`timescale 1ns/10ps
module ssc_sdram_model
	import ssc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic [ROWS-1:0] sel_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [BANK_W-1:0] bank_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] dqm_i,
	input wire logic [DATA_W-1:0] dq_i,
	input wire logic dq_oe_i,
	input wire logic [1:0] cas_lat_i,
	output logic [DATA_W-1:0] dq_o
);
	logic [DATA_W-1:0] mem [bit [27:0]];
	logic [ADDR_W-1:0] open_r [ROWS][4];
	logic [3:0] pv = '0;
	logic [DATA_W-1:0] pd [4];
	logic [DATA_W-1:0] last = '0;
	logic [DATA_W-1:0] wd;
	logic [2:0] rix;
	bit [27:0] key;
	always_comb begin
		rix = '0;
		for (int i = 0; i < ROWS; i++)
			if (!sel_n_i[i])
				rix = 3'(i);
		key = {rix, bank_i, open_r[rix][bank_i], addr_i[9:0]};
	end
	// Released bus shows the inverse of the last word so a stale capture cannot pass
	assign dq_o = pv[0] ? pd[0] : ~last;
	always @(posedge clk_sys_i) begin
		pv <= pv >> 1;
		for (int i = 0; i < 3; i++)
			pd[i] <= pd[i + 1];
		if (pv[0])
			last <= pd[0];
		if (~&sel_n_i) begin
			case ({ras_n_i, cas_n_i, we_n_i})
				3'b011: open_r[rix][bank_i] <= addr_i;
				3'b100: begin
					wd = mem.exists(key) ? mem[key] : '0;
					for (int b = 0; b < 8; b++)
						if (!dqm_i[b])
							wd[8 * b +: 8] = dq_oe_i ? dq_i[8 * b +: 8] : ~dq_i[8 * b +: 8];
					mem[key] = wd;
				end
				3'b101: begin
					pv[cas_lat_i - 1] <= 1'b1;
					pd[cas_lat_i - 1] <= mem.exists(key) ? mem[key] : '0;
				end
				default: ;
			endcase
		end
	end
endmodule

// [bench/ssc_controller_test.sv]
`timescale 1ns/10ps
module ssc_controller_test;
	import ssc_pkg::*;
	logic clk_sys_i = 0, reset_i = 1, req_valid_i = 0, req_write_i = 0;
	logic [CMD_ADDR_W-1:0] req_addr_i = '0;
	logic [ROW_IDX_W-1:0] req_row_i = '0;
	logic [DATA_W-1:0] req_wdata_i = '0, rd_data_o, mem_dq_o, mem_dq_i, mdl_dq;
	logic [7:0] req_wmask_i = 8'hff, mem_dqm_o;
	logic [2:0] cfg_org_i = ORG_32M, cfg_open_pages_i = 3'h4;
	logic [1:0] cfg_cas_lat_i = CL2;
	logic [TMR_W-1:0] cfg_trp_i = TRP_DEF, cfg_trcd_i = TRCD_DEF, cfg_trc_i = TRC_DEF;
	logic [REF_INT_W-1:0] cfg_ref_int_i = 12'hfff;
	logic [ROWS-1:0] cfg_pwrdn_i = '0, mem_row_select_n_a_o, mem_row_select_n_b_o, mem_row_clk_en_o;
	logic req_ready_o, rd_valid_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o, mem_dq_oe_o;
	logic [ADDR_W-1:0] mem_mux_addr_o, act_row, rd_col;
	logic [BANK_W-1:0] mem_bank_sel_o, act_bank;
	logic [REFQ_CNT_W-1:0] refq_level_o;
	int num_errors = 0, tests_run = 0, n_act = 0, n_pre = 0, n_ref = 0;
	// One fixed memory clock; picking the rate for the row count is firmware's job
	always #4 clk_sys_i = ~clk_sys_i;
	assign mem_dq_i = mem_dq_oe_o ? mem_dq_o : mdl_dq;
	ssc_controller DUT (.clk_sys_i, .reset_i, .req_valid_i, .req_write_i, .req_addr_i, .req_row_i,
		.req_wdata_i, .req_wmask_i, .req_ready_o, .rd_valid_o, .rd_data_o, .cfg_org_i,
		.cfg_cas_lat_i, .cfg_open_pages_i, .cfg_trp_i, .cfg_trcd_i, .cfg_trc_i, .cfg_ref_int_i,
		.cfg_pwrdn_i, .mem_mux_addr_o, .mem_bank_sel_o, .mem_row_select_n_a_o,
		.mem_row_select_n_b_o, .mem_row_clk_en_o, .mem_ras_n_o, .mem_cas_n_o, .mem_we_n_o,
		.mem_dqm_o, .mem_dq_o, .mem_dq_oe_o, .mem_dq_i, .refq_level_o);
	ssc_sdram_model u_mem (.clk_sys_i, .sel_n_i(mem_row_select_n_a_o), .ras_n_i(mem_ras_n_o),
		.cas_n_i(mem_cas_n_o), .we_n_i(mem_we_n_o), .bank_i(mem_bank_sel_o),
		.addr_i(mem_mux_addr_o), .dqm_i(mem_dqm_o), .dq_i(mem_dq_o), .dq_oe_i(mem_dq_oe_o),
		.cas_lat_i(cfg_cas_lat_i), .dq_o(mdl_dq));
	always @(posedge clk_sys_i) begin
		if (~&mem_row_select_n_a_o) begin
			case ({mem_ras_n_o, mem_cas_n_o, mem_we_n_o})
				3'b011: begin
					n_act++;
					act_row = mem_mux_addr_o;
					act_bank = mem_bank_sel_o;
				end
				3'b010: n_pre++;
				3'b001: n_ref++;
				3'b101: rd_col = mem_mux_addr_o;
				default: ;
			endcase
		end
	end
	function automatic logic [63:0] pat(input int a, input int b);
		return {32'(a), 32'(b)} ^ 64'hc3a5_0f96_5a3c_e187;
	endfunction
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_of_test;
		if (num_errors == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Ready is a flop, so its value at the falling edge is what the next rising edge takes
	task automatic req(input logic w, input logic [27:0] a, input logic [2:0] r,
		input logic [63:0] d, input logic [7:0] m);
		int n;
		@(negedge clk_sys_i);
		req_valid_i = 1'b1;
		req_write_i = w;
		req_addr_i = a;
		req_row_i = r;
		req_wdata_i = d;
		req_wmask_i = m;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 500) begin
			@(negedge clk_sys_i);
			n++;
		end
		chk("request accepted", 1, 64'(n < 500));
		@(negedge clk_sys_i);
		req_valid_i = 1'b0;
	endtask
	task automatic rd_wait(output logic [63:0] d);
		int n;
		n = 0;
		while (rd_valid_o !== 1'b1 && n < 100) begin
			@(negedge clk_sys_i);
			n++;
		end
		d = (n < 100) ? rd_data_o : 'x;
	endtask
	task automatic rd(input logic [27:0] a, input logic [2:0] r, output logic [63:0] d);
		req(1'b0, a, r, '0, 8'hff);
		rd_wait(d);
	endtask
	task automatic t_pwrdn;
		@(negedge clk_sys_i);
		cfg_pwrdn_i = 6'h2a;
		repeat (2) @(negedge clk_sys_i);
		chk("row clock enables", 64'h15, 64'(mem_row_clk_en_o));
		cfg_pwrdn_i = 6'h00;
		repeat (2) @(negedge clk_sys_i);
	endtask
	task automatic t_rw;
		logic [63:0] d;
		for (int k = 2; k < 4; k++) begin
			@(negedge clk_sys_i);
			cfg_cas_lat_i = 2'(k);
			for (int r = 0; r < ROWS; r++)
				req(1'b1, 28'(r * 1031 + k), 3'(r), pat(r, k), 8'hff);
			repeat (40) @(negedge clk_sys_i);
			for (int r = 0; r < ROWS; r++) begin
				rd(28'(r * 1031 + k), 3'(r), d);
				chk("read data", pat(r, k), d);
			end
		end
	endtask
	task automatic t_bypass;
		logic [63:0] d;
		req(1'b1, 28'h12345, 3'h1, 64'h1111_2222_3333_4444, 8'hff);
		repeat (40) @(negedge clk_sys_i);
		// Write and read of one word back to back: the read overtakes the posted write
		@(negedge clk_sys_i);
		req_valid_i = 1'b1;
		req_write_i = 1'b1;
		req_addr_i = 28'h12345;
		req_row_i = 3'h1;
		req_wdata_i = '1;
		req_wmask_i = 8'h0f;
		chk("ready for posted write", 1, 64'(req_ready_o));
		@(negedge clk_sys_i);
		req_write_i = 1'b0;
		chk("ready for bypassing read", 1, 64'(req_ready_o));
		@(negedge clk_sys_i);
		req_valid_i = 1'b0;
		rd_wait(d);
		chk("read past buffered write", 64'h1111_2222_3333_4444, d);
		rd(28'd1033, 3'h1, d);
		chk("read of other word", pat(1, 2), d);
		repeat (40) @(negedge clk_sys_i);
		rd(28'h12345, 3'h1, d);
		chk("byte masked write", 64'h1111_2222_ffff_ffff, d);
	endtask
	task automatic t_org;
		logic [63:0] d;
		int cw;
		@(negedge clk_sys_i);
		cfg_open_pages_i = 3'h0;
		for (int o = 0; o < 5; o++) begin
			cw = (o == 0) ? 8 : (o < 3) ? 9 : 10;
			@(negedge clk_sys_i);
			cfg_org_i = 3'(o);
			rd(28'(((12'h0a5 + o) << (cw + 2)) | ((o % 4) << cw) | ((1 << cw) - 1)), 3'(o), d);
			chk("row address", 64'(12'h0a5 + o), 64'(act_row));
			chk("bank", 64'(o % 4), 64'(act_bank));
			chk("column", 64'((1 << cw) - 1), 64'(rd_col & 13'((1 << cw) - 1)));
		end
		cfg_org_i = ORG_32M;
	endtask
	task automatic t_page;
		logic [63:0] d;
		int a0, p0;
		@(negedge clk_sys_i);
		cfg_open_pages_i = 3'h4;
		rd(28'h0040100, 3'h2, d);
		a0 = n_act;
		p0 = n_pre;
		rd(28'h0040100, 3'h2, d);
		chk("page hit activates", 0, n_act - a0);
		rd(28'h0050100, 3'h2, d);
		chk("page miss activates", 1, n_act - a0);
		chk("page miss precharges", 1, n_pre - p0);
		rd(28'h0040500, 3'h2, d);
		a0 = n_act;
		rd(28'h0050100, 3'h2, d);
		chk("second bank page kept", 0, n_act - a0);
		cfg_open_pages_i = 3'h0;
		rd(28'h0050100, 3'h2, d);
		a0 = n_act;
		rd(28'h0050100, 3'h2, d);
		chk("closed page activates", 1, n_act - a0);
	endtask
	task automatic t_ref;
		int r0;
		@(negedge clk_sys_i);
		cfg_ref_int_i = 12'h010;
		r0 = n_ref;
		repeat (200) @(negedge clk_sys_i);
		chk("refreshes issued", 1, 64'(n_ref - r0 >= 8));
		cfg_ref_int_i = 12'hfff;
		repeat (40) @(negedge clk_sys_i);
		chk("refresh queue level", 0, 64'(refq_level_o));
	endtask
	initial begin
		repeat (4) @(negedge clk_sys_i);
		chk("selects in reset", 64'h3f, 64'(mem_row_select_n_a_o));
		chk("enables in reset", 0, 64'(mem_row_clk_en_o));
		reset_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk("enables after reset", 64'h3f, 64'(mem_row_clk_en_o));
		t_pwrdn;
		t_rw;
		t_bypass;
		t_org;
		t_page;
		t_ref;
		end_of_test;
	end
	initial begin
		#160000;
		num_errors++;
		end_of_test;
	end
endmodule
